// file: bench/scfp_link_asserts.sv
// pin-level checks on the link between host end and flash end
`timescale 1ns/1ps
module scfp_link_asserts
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic serialClock,
   input wire logic chipSelectN,
   input wire logic serialDataIn,
   input wire logic dataOut,
   input wire logic dataOutEnN
);
   logic selSeen_q;
   logic selSeen_d;

   always_comb
   begin
      selSeen_d = selSeen_q | ~chipSelectN;
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         selSeen_q <= 1'b0;
      else
         selSeen_q <= selSeen_d;
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   sequence clkHigh;
      serialClock [*4] ##1 !serialClock;
   endsequence
   sequence clkLow;
      !serialClock [*4];
   endsequence

   chk_clk_high: assert property ($rose(serialClock) |-> clkHigh)
      else $error("serial clock high phase wrong");
   chk_clk_low: assert property ($fell(serialClock) |-> clkLow)
      else $error("serial clock low phase wrong");
   chk_clk_desel: assert property (chipSelectN |-> !serialClock)
      else $error("serial clock moves while deselected");
   chk_desel_hiz: assert property (chipSelectN [*5] |-> dataOutEnN)
      else $error("data driven while deselected");
   chk_sel_drive: assert property (!chipSelectN [*5] |-> !dataOutEnN)
      else $error("data not driven while selected");
   chk_out_edge: assert property
      (!dataOutEnN && $changed(dataOut) |-> !serialClock)
      else $error("data changed while serial clock high");
   chk_in_stable: assert property (serialClock |-> $stable(serialDataIn))
      else $error("input data moved while serial clock high");
   chk_sel_gap: assert property ($rose(chipSelectN) |-> chipSelectN [*4])
      else $error("select gap too short");
   chk_first_fall: assert property (!selSeen_q |-> dataOutEnN)
      else $error("data driven before first select fall");
endmodule : scfp_link_asserts

// file: bench/tb_top.sv
// self-checking bench joining host end and flash end over the link
`timescale 1ns/1ps
module tb_top
   import scfp_pkg::*;
;
   logic       sys_clk;
   logic       arst_n;
   scfp_byte_t cmdByte;
   logic       cmdValid;
   logic       cmdLast;
   logic       cmdReady;
   scfp_byte_t rspByte;
   logic       rspValid;
   logic       busy;
   scfp_byte_t rxByte;
   logic       rxValid;
   logic       rxReady;
   scfp_byte_t txByte;
   logic       txValid;
   logic       txReady;
   logic       holdRx;
   logic       selected;
   int         error_cnt = 0;
   int         n_tests = 0;
   scfp_byte_t rxQ[$];
   scfp_byte_t rspQ[$];

   scfp_link_if i_scfp_link_if ();

   scfp_host_end i_scfp_host_end
   (
      .sys_clk  (sys_clk),
      .arst_n   (arst_n),
      .link     (i_scfp_link_if),
      .cmdByte  (cmdByte),
      .cmdValid (cmdValid),
      .cmdLast  (cmdLast),
      .cmdReady (cmdReady),
      .rspByte  (rspByte),
      .rspValid (rspValid),
      .busy     (busy)
   );

   scfp_flash_end i_scfp_flash_end
   (
      .sys_clk  (sys_clk),
      .arst_n   (arst_n),
      .link     (i_scfp_link_if),
      .rxByte   (rxByte),
      .rxValid  (rxValid),
      .rxReady  (rxReady),
      .txByte   (txByte),
      .txValid  (txValid),
      .txReady  (txReady),
      .selected (selected)
   );

   scfp_link_asserts i_scfp_link_asserts
   (
      .sys_clk      (sys_clk),
      .arst_n       (arst_n),
      .serialClock  (i_scfp_link_if.serialClock),
      .chipSelectN  (i_scfp_link_if.chipSelectN),
      .serialDataIn (i_scfp_link_if.serialDataIn),
      .dataOut      (i_scfp_link_if.dataOut),
      .dataOutEnN   (i_scfp_link_if.dataOutEnN)
   );

   task automatic report_and_stop();
      $display("errors %0d checks %0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : report_and_stop

   task automatic check(input scfp_byte_t seen, input scfp_byte_t exp);
      n_tests++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic waitLow(input bit onRx);
      int k;
      k = 0;
      while ((onRx ? rxValid : busy) !== 1'b0 && k < 500)
      begin
         @(posedge sys_clk);
         k++;
      end
      if (k >= 500)
      begin
         error_cnt++;
         report_and_stop();
      end
   endtask : waitLow

   // with fill set the fifo keeps the first 8 bytes and its holding
   // register the newest one; the bytes in between are lost
   task automatic sendFrame(input int n, input bit fill);
      scfp_byte_t b;
      int         k;
      for (int i = 0; i < n; i++)
      begin
         b = scfp_byte_t'($urandom);
         cmdByte  <= b;
         cmdValid <= 1'b1;
         cmdLast  <= (i == n - 1);
         k = 0;
         do
         begin
            @(posedge sys_clk);
            k++;
         end
         while (cmdReady !== 1'b1 && k < 200);
         if (k >= 200)
         begin
            error_cnt++;
            report_and_stop();
         end
         if (!fill || i < 8 || i == n - 1)
            rxQ.push_back(b);
         if (txValid !== 1'b1)
            rspQ.push_back(8'hff);
      end
      cmdValid <= 1'b0;
      waitLow(1'b0);
      // let the flash end see the last clock fall and the select rise that closes the frame
      repeat (8) @(posedge sys_clk);
      check({7'h00, selected}, 8'h00);
      check(8'(rspQ.size()), {7'h00, txValid});
      // drop the byte taken at the last boundary, never shifted out
      rspQ.delete();
   endtask : sendFrame

   always #20 sys_clk = ~sys_clk;

   always @(posedge sys_clk)
   begin
      rxReady <= holdRx ? 1'b0 : 1'($urandom);
      if (txReady === 1'b1)
      begin
         rspQ.push_back(txByte);
         txByte <= scfp_byte_t'($urandom);
      end
   end

   always @(posedge sys_clk)
   begin
      if (rspValid === 1'b1)
      begin
         check(rspByte, rspQ.size() ? rspQ.pop_front() : 8'hxx);
         check({7'h00, selected}, 8'h01);
      end
      if (rxValid === 1'b1 && rxReady === 1'b1)
         check(rxByte, rxQ.size() ? rxQ.pop_front() : 8'hxx);
   end

   initial
   begin
      void'($urandom(32'hb0dd46c6));
      sys_clk  = 1'b0;
      arst_n   = 1'b0;
      cmdByte  = 8'h00;
      cmdValid = 1'b0;
      cmdLast  = 1'b0;
      txValid  = 1'b1;
      txByte   = scfp_byte_t'($urandom);
      holdRx   = 1'b0;
      rxReady  = 1'b0;
      repeat (4) @(posedge sys_clk);
      arst_n <= 1'b1;
      for (int f = 0; f < 6; f++)
      begin
         // one frame with nothing offered: the flash sends all ones
         txValid <= (f != 3);
         sendFrame(1 + $urandom_range(3), 1'b0);
      end
      waitLow(1'b1);
      holdRx <= 1'b1;
      sendFrame(10, 1'b1);
      check({7'h00, rxValid}, 8'h01);
      holdRx <= 1'b0;
      waitLow(1'b1);
      check(8'(rxQ.size()), 8'h00);
      report_and_stop();
   end
endmodule : tb_top

// file: verilog/scfp_fifo.sv
// parameterised valid/ready fifo
`timescale 1ns/1ps
module scfp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
)
(
   input  wire logic             sys_clk,
   input  wire logic             arst_n,
   input  wire logic [WIDTH-1:0] inData,
   input  wire logic             inValid,
   output logic                  inReady,
   output logic      [WIDTH-1:0] outData,
   output logic                  outValid,
   input  wire logic             outReady
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
   logic [AW:0]      cnt_q, cnt_d;
   logic             doWr, doRd;

   always_comb
   begin
      doWr    = inValid && (cnt_q != (AW+1)'(DEPTH));
      doRd    = outReady && (cnt_q != '0);
      wrPtr_d = doWr ? AW'(wrPtr_q + 1'b1) : wrPtr_q;
      rdPtr_d = doRd ? AW'(rdPtr_q + 1'b1) : rdPtr_q;
      cnt_d   = cnt_q;
      if (doWr && !doRd)
      begin
         cnt_d = (AW+1)'(cnt_q + 1'b1);
      end
      else if (doRd && !doWr)
      begin
         cnt_d = (AW+1)'(cnt_q - 1'b1);
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         cnt_q   <= '0;
      end
      else
      begin
         wrPtr_q <= wrPtr_d;
         rdPtr_q <= rdPtr_d;
         cnt_q   <= cnt_d;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (doWr)
      begin
         mem[wrPtr_q] <= inData;
      end
   end

   assign inReady  = (cnt_q != (AW+1)'(DEPTH));
   assign outValid = (cnt_q != '0);
   assign outData  = mem[rdPtr_q];
endmodule : scfp_fifo

// file: verilog/scfp_flash_end.sv
// flash end of the serial configuration port
// What this block does
// - output changes only after serial clock falls or select falls
// - input sampled on serial clock rising edge
// - select high: output held high impedance
// - select low: device active, takes instructions
// - host frames each instruction with select
// - no operation before first select falling edge
// - host alone drives the serial clock
// - host captures output on next falling edge
`timescale 1ns/1ps
`include "scfp_params.svh"
module scfp_flash_end
   import scfp_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       arst_n,
   scfp_link_if.flash      link,
   output scfp_byte_t      rxByte,
   output logic            rxValid,
   input  wire logic       rxReady,
   input  scfp_byte_t      txByte,
   input  wire logic       txValid,
   output logic            txReady,
   output logic            selected
);
   localparam int              NPIN    = 3;
   // stage reset levels: select idles high, so no false fall after reset
   localparam logic [NPIN-1:0] PIN_RST = 3'b010;

   logic [NPIN-1:0] pinRaw;
   wire  [NPIN-1:0] pinSync;
   logic            sclkSync;
   logic            csSync;
   logic            sdiSync;
   logic            sclkOld_q;
   logic            csOld_q;
   logic            armed_q;
   logic            armed_d;
   logic [2:0]      bitCnt_q;
   logic [2:0]      bitCnt_d;
   scfp_byte_t      shIn_q;
   scfp_byte_t      shIn_d;
   scfp_byte_t      shOut_q;
   scfp_byte_t      shOut_d;
   logic            dOut_q;
   logic            dOut_d;
   logic            dEnN_q;
   logic            dEnN_d;
   logic            fifoInValid_q;
   logic            fifoInValid_d;
   logic            fifoInReady;
   scfp_byte_t      fifoIn_q;
   scfp_byte_t      fifoIn_d;
   logic            txReady_q;
   logic            txReady_d;
   logic            sel_q;
   logic            sel_d;
   logic [8:0]      txLoad;
   logic            rise;
   logic            fall;
   logic            csFall;

   // true in the cycle a level moves from low to high
   function automatic logic upEdge
   (
      input logic now,
      input logic old
   );
      upEdge = now && !old;
   endfunction : upEdge

   // first bit and shift pattern of the next byte; all ones when none waits
   function automatic logic [8:0] nextTx
   (
      input logic       valid,
      input scfp_byte_t b
   );
      nextTx = valid ? {b, 1'b1} : 9'h1ff;
   endfunction : nextTx

   assign pinRaw = {link.serialDataIn, link.chipSelectN, link.serialClock};

   // two flip-flops on every pin before any logic reads it
   generate
      for (genvar g = 0; g < NPIN; g++)
      begin : gSync
         logic s1_q;
         logic s2_q;
         always_ff @(posedge sys_clk or negedge arst_n)
         begin
            if (!arst_n)
            begin
               s1_q <= PIN_RST[g];
               s2_q <= PIN_RST[g];
            end
            else
            begin
               s1_q <= pinRaw[g];
               s2_q <= s1_q;
            end
         end
         assign pinSync[g] = s2_q;
      end
   endgenerate

   assign sclkSync = pinSync[0];
   assign csSync   = pinSync[1];
   assign sdiSync  = pinSync[2];

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sclkOld_q <= 1'b0;
         csOld_q   <= 1'b1;
      end
      else
      begin
         sclkOld_q <= sclkSync;
         csOld_q   <= csSync;
      end
   end

   assign rise   = upEdge(sclkSync, sclkOld_q) && !csSync;
   assign fall   = upEdge(!sclkSync, !sclkOld_q) && !csSync;
   assign csFall = upEdge(!csSync, !csOld_q);

   always_comb
   begin
      txLoad        = nextTx(txValid, txByte);
      armed_d       = armed_q || csFall;
      bitCnt_d      = bitCnt_q;
      shIn_d        = shIn_q;
      shOut_d       = shOut_q;
      dOut_d        = dOut_q;
      dEnN_d        = csSync || !armed_q;
      fifoInValid_d = fifoInValid_q && !fifoInReady;
      fifoIn_d      = fifoIn_q;
      txReady_d     = 1'b0;
      sel_d         = !csSync && armed_q;
      if (csFall)
      begin
         // the first bit stands before the first rising edge
         bitCnt_d  = 3'h0;
         dOut_d    = txLoad[8];
         shOut_d   = txLoad[7:0];
         txReady_d = txValid;
      end
      else if (armed_q && rise)
      begin
         shIn_d   = {shIn_q[6:0], sdiSync};
         bitCnt_d = 3'(bitCnt_q + 1'b1);
         if (bitCnt_q == 3'h7)
         begin
            fifoIn_d      = {shIn_q[6:0], sdiSync};
            fifoInValid_d = 1'b1;
         end
      end
      else if (armed_q && fall)
      begin
         dOut_d  = shOut_q[7];
         shOut_d = {shOut_q[6:0], 1'b1};
         if (bitCnt_q == 3'h0)
         begin
            dOut_d    = txLoad[8];
            shOut_d   = txLoad[7:0];
            txReady_d = txValid;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         armed_q       <= 1'b0;
         bitCnt_q      <= 3'h0;
         shIn_q        <= 8'h00;
         shOut_q       <= 8'hff;
         dOut_q        <= 1'b1;
         dEnN_q        <= 1'b1;
         fifoInValid_q <= 1'b0;
         fifoIn_q      <= 8'h00;
         txReady_q     <= 1'b0;
         sel_q         <= 1'b0;
      end
      else
      begin
         armed_q       <= armed_d;
         bitCnt_q      <= bitCnt_d;
         shIn_q        <= shIn_d;
         shOut_q       <= shOut_d;
         dOut_q        <= dOut_d;
         dEnN_q        <= dEnN_d;
         fifoInValid_q <= fifoInValid_d;
         fifoIn_q      <= fifoIn_d;
         txReady_q     <= txReady_d;
         sel_q         <= sel_d;
      end
   end

   scfp_fifo #(.WIDTH(`SCFP_WORD_BITS), .DEPTH(`SCFP_FIFO_DEPTH)) rxFifo
   (
      .sys_clk  (sys_clk),
      .arst_n   (arst_n),
      .inData   (fifoIn_q),
      .inValid  (fifoInValid_q),
      .inReady  (fifoInReady),
      .outData  (rxByte),
      .outValid (rxValid),
      .outReady (rxReady)
   );

   assign link.dataOut    = dOut_q;
   assign link.dataOutEnN = dEnN_q;
   assign txReady         = txReady_q;
   assign selected        = sel_q;
endmodule : scfp_flash_end

// file: verilog/scfp_host_end.sv
// host end: frames byte transfers and makes the serial clock
`timescale 1ns/1ps
`include "scfp_params.svh"
module scfp_host_end
   import scfp_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       arst_n,
   scfp_link_if.host       link,
   input  scfp_byte_t      cmdByte,
   input  wire logic       cmdValid,
   input  wire logic       cmdLast,
   output logic            cmdReady,
   output scfp_byte_t      rspByte,
   output logic            rspValid,
   output logic            busy
);
   scfp_hst_e  st_q, st_d;
   logic [3:0] div_q, div_d;
   logic [2:0] bit_q, bit_d;
   scfp_byte_t sh_q, sh_d, rx_q, rx_d, rsp_q, rsp_d;
   logic       last_q, last_d, clk_q, clk_d, cs_q, cs_d, sdo_q, sdo_d;
   logic       rdy_q, rdy_d, rv_q, rv_d, din1, din2;
   logic       busy_q, busy_d;

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         din1 <= 1'b1;
         din2 <= 1'b1;
      end
      else
      begin
         din1 <= link.dataOut;
         din2 <= din1;
      end
   end

   always_comb
   begin
      st_d = st_q; div_d = div_q; bit_d = bit_q; sh_d = sh_q;
      rx_d = rx_q; rsp_d = rsp_q; last_d = last_q; clk_d = clk_q;
      cs_d = cs_q; sdo_d = sdo_q; rdy_d = 1'b0; rv_d = 1'b0;
      case (st_q)
         HST_IDLE:
         begin
            clk_d = 1'b0;
            if (div_q != 4'h0)
            begin
               div_d = 4'(div_q - 1'b1);
            end
            else if (cmdValid)
            begin
               cs_d   = 1'b0;
               sh_d   = {cmdByte[6:0], 1'b0};
               sdo_d  = cmdByte[7];
               last_d = cmdLast;
               rdy_d  = 1'b1;
               bit_d  = 3'h0;
               div_d  = 4'(`SCFP_CLK_HALF_CYC - 1);
               st_d   = HST_LOW;
            end
         end
         HST_LOW:
         begin
            if (div_q != 4'h0)
            begin
               div_d = 4'(div_q - 1'b1);
            end
            else
            begin
               clk_d = 1'b1;
               div_d = 4'(`SCFP_CLK_HALF_CYC - 1);
               st_d  = HST_HIGH;
            end
         end
         HST_HIGH:
         begin
            if (div_q != 4'h0)
            begin
               div_d = 4'(div_q - 1'b1);
            end
            else
            begin
               clk_d = 1'b0;
               // bit launched after the previous fall is taken now
               rx_d  = {rx_q[6:0], din2};
               div_d = 4'(`SCFP_CLK_HALF_CYC - 1);
               bit_d = 3'(bit_q + 1'b1);
               sdo_d = sh_q[7];
               sh_d  = {sh_q[6:0], 1'b0};
               st_d  = HST_LOW;
               if (bit_q == 3'h7)
               begin
                  rsp_d = {rx_q[6:0], din2};
                  rv_d  = 1'b1;
                  if (last_q || !cmdValid)
                  begin
                     st_d = HST_END;
                  end
                  else
                  begin
                     sdo_d  = cmdByte[7];
                     sh_d   = {cmdByte[6:0], 1'b0};
                     last_d = cmdLast;
                     rdy_d  = 1'b1;
                  end
               end
            end
         end
         HST_END:
         begin
            cs_d  = 1'b1;
            div_d = 4'(`SCFP_SEL_GAP_CYC);
            st_d  = HST_IDLE;
         end
         default:
         begin
            st_d = HST_IDLE;
         end
      endcase
      busy_d = (st_d != HST_IDLE);
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_q <= HST_IDLE; div_q <= 4'h0; bit_q <= 3'h0;
         sh_q <= 8'h00; rx_q <= 8'h00; rsp_q <= 8'h00;
         last_q <= 1'b0; clk_q <= 1'b0; cs_q <= 1'b1;
         sdo_q <= 1'b0; rdy_q <= 1'b0; rv_q <= 1'b0;
         busy_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d; div_q <= div_d; bit_q <= bit_d;
         sh_q <= sh_d; rx_q <= rx_d; rsp_q <= rsp_d;
         last_q <= last_d; clk_q <= clk_d; cs_q <= cs_d;
         sdo_q <= sdo_d; rdy_q <= rdy_d; rv_q <= rv_d;
         busy_q <= busy_d;
      end
   end

   assign link.serialClock  = clk_q;
   assign link.chipSelectN  = cs_q;
   assign link.serialDataIn = sdo_q;
   assign cmdReady          = rdy_q;
   assign rspByte           = rsp_q;
   assign rspValid          = rv_q;
   assign busy              = busy_q;
endmodule : scfp_host_end

// file: verilog/scfp_link_if.sv
// pin-level link between the flash end and the host end
`timescale 1ns/1ps
interface scfp_link_if;
   logic serialClock;
   logic chipSelectN;
   logic serialDataIn;
   logic dataOut;
   logic dataOutEnN;
   modport flash
   (
      input  serialClock,
      input  chipSelectN,
      input  serialDataIn,
      output dataOut,
      output dataOutEnN
   );
   modport host
   (
      output serialClock,
      output chipSelectN,
      output serialDataIn,
      input  dataOut,
      input  dataOutEnN
   );
endinterface : scfp_link_if

// file: verilog/scfp_params.svh
// timing counts and field widths for the serial config flash port
`ifndef SCFP_PARAMS_SVH
`define SCFP_PARAMS_SVH
`define SCFP_WORD_BITS     8
`define SCFP_FIFO_DEPTH    8
`define SCFP_CLK_HALF_NS   160
`define SCFP_SYS_CLK_NS    40
`define SCFP_CLK_HALF_CYC  (`SCFP_CLK_HALF_NS / `SCFP_SYS_CLK_NS)
`define SCFP_SEL_GAP_CYC   4
`endif

// file: verilog/scfp_pkg.sv
// shared types for the serial config flash port
package scfp_pkg;
   typedef logic [7:0] scfp_byte_t;
   typedef enum logic [3:0]
   {
      HST_IDLE  = 4'b0001,
      HST_LOW   = 4'b0010,
      HST_HIGH  = 4'b0100,
      HST_END   = 4'b1000
   } scfp_hst_e;
endpackage : scfp_pkg
